/* hdl/setws_fifo.sv */
// Small parameterised FIFO with valid/ready on both sides.
// Assumes one clock; inReady low means a push is refused.
module setws_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("setws_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PTR_W-1:0]            wrPtr;
    logic [PTR_W-1:0]            rdPtr;
    logic [PTR_W:0]              count;
  } setws_fifo_state_type;

  setws_fifo_state_type s_q;
  setws_fifo_state_type s_d;
  logic                 doPush;
  logic                 doPop;

  // Count is one bit wider than the pointers so that full is DEPTH itself
  assign inReady  = (s_q.count != (PTR_W+1)'(DEPTH));
  assign outValid = (s_q.count != '0);
  assign outData  = s_q.slot[s_q.rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always_comb begin
    s_d = s_q;
    if (doPush) begin
      s_d.slot[s_q.wrPtr] = inData;
      s_d.wrPtr           = s_q.wrPtr + 1'b1;
    end
    if (doPop) begin
      s_d.rdPtr = s_q.rdPtr + 1'b1;
    end
    case ({doPush, doPop})
      2'b10:   s_d.count = s_q.count + 1'b1;
      2'b01:   s_d.count = s_q.count - 1'b1;
      default: s_d.count = s_q.count;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : setws_fifo

/* hdl/setws_pkg.sv */
// Shared constants and carrier types of the two-wire serial memory slave.
// Assumes a single 25 MHz ref_clk domain; bus pins arrive asynchronously.
package setws_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned WRITE_TIME_MS = 5;
  // Longest time, so the count rounds down
  localparam int unsigned WRITE_CYCLES  = (CLK_HZ / 1000) * WRITE_TIME_MS;
  localparam int unsigned TIMER_W       = 24;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MEM_WORDS = 65536;
  localparam int unsigned PAGE_W    = 7;
  localparam int unsigned PAGE_SIZE = 128;
  localparam int unsigned PAGE_NUM  = 512;
  localparam int unsigned FIFO_DEPTH = 4;

  // ---------------------------------------------------------------------
  // Pin vector layout and reset values
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       writeInhibit;
    logic [2:0] selectInput;
    logic       sda;
    logic       scl;
  } setws_pins_type;

  localparam int unsigned PINS_W = 6;
  // Idle bus is high, straps and inhibit read low like their pull-downs
  localparam setws_pins_type PINS_RESET = '{writeInhibit: 1'b0,
                                            selectInput:  3'h0,
                                            sda:          1'b1,
                                            scl:          1'b1};

  typedef struct packed {
    logic [PAGE_W-1:0] offset;
    logic [DATA_W-1:0] data;
  } setws_wbyte_type;

  localparam int unsigned WBYTE_W = PAGE_W + DATA_W;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_AHI  = 3'h3,
    ST_ALO  = 3'h2,
    ST_WDAT = 3'h6,
    ST_RDAT = 3'h7
  } setws_state_type;

  localparam logic [3:0] BIT_FULL = 4'h8;

endpackage : setws_pkg

/* hdl/setws_slave.sv */
// Two-wire serial memory slave: 64K x 8 array, page writes, write inhibit.
// Assumes bus pins, straps and inhibit are asynchronous to ref_clk and an
// outside pad resolves the open-drain data wire from sdaOe.
module setws_slave #(
  parameter int unsigned WRITE_CYCLES = setws_pkg::WRITE_CYCLES,
  parameter logic [3:0]  DEVICE_CODE  = 4'hA
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic select_input_bit0,
  input  wire logic select_input_bit1,
  input  wire logic select_input_bit2,
  input  wire logic writeInhibit,
  output logic      writeBusy
);

  initial begin
    if (WRITE_CYCLES < setws_pkg::PAGE_SIZE + 1 ||
        WRITE_CYCLES >= (1 << setws_pkg::TIMER_W)) begin
      $error("setws_slave: WRITE_CYCLES out of range");
    end
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    setws_pkg::setws_pins_type       sync1;
    setws_pkg::setws_pins_type       sync2;
    setws_pkg::setws_pins_type       sync3;
    setws_pkg::setws_pins_type       filt;
    logic                            sclPrev;
    logic                            sdaPrev;
    setws_pkg::setws_state_type      state;
    logic [3:0]                      bitCnt;
    logic [7:0]                      shift;
    logic                            ackSlot;
    logic                            sdaLow;
    logic [setws_pkg::ADDR_W-1:0]    addr;
    logic [8:0]                      pageBase;
    logic [setws_pkg::PAGE_SIZE-1:0] mask;
    logic                            wrAct;
    logic                            pending;
    logic                            busy;
    logic [7:0]                      commitIdx;
    logic [setws_pkg::TIMER_W-1:0]   timer;
  } setws_slave_state_type;

  setws_slave_state_type         s_q;
  setws_slave_state_type         s_d;
  setws_pkg::setws_pins_type     pinsNow;
  setws_pkg::setws_pins_type     agree;
  setws_pkg::setws_wbyte_type    pushByte;
  setws_pkg::setws_wbyte_type    popByte;
  logic                          push;
  logic                          fifoReady;
  logic                          fifoValid;
  logic                          memWe;
  logic [setws_pkg::ADDR_W-1:0]  memAddr;
  logic [setws_pkg::DATA_W-1:0]  rdData_q;
  logic                          scl;
  logic                          sda;
  logic                          sclRise;
  logic                          sclFall;
  logic                          startCond;
  logic                          stopCond;
  logic [6:0]                    myAddr;

  // Storage arrays sit beside the state record: too large for a reset
  logic [setws_pkg::DATA_W-1:0] memArray [setws_pkg::MEM_WORDS];
  logic [setws_pkg::DATA_W-1:0] pageBuf  [setws_pkg::PAGE_SIZE];

  // Straps are plain inputs; pad pull-downs make a floating pin low
  assign pinsNow = '{writeInhibit: writeInhibit,
                     selectInput:  {select_input_bit2, select_input_bit1,
                                    select_input_bit0},
                     sda:          sdaIn,
                     scl:          sclIn};

  // Never drive high; the pad only pulls the wire low
  assign sdaOut    = 1'b0;
  assign sdaOe     = s_q.sdaLow;
  assign writeBusy = s_q.busy;

  assign scl       = s_q.filt.scl;
  assign sda       = s_q.filt.sda;
  assign sclRise   = scl & ~s_q.sclPrev;
  assign sclFall   = ~scl & s_q.sclPrev;
  assign startCond = scl & s_q.sclPrev & s_q.sdaPrev & ~sda;
  assign stopCond  = scl & s_q.sclPrev & ~s_q.sdaPrev & sda;
  assign myAddr    = {DEVICE_CODE, s_q.filt.selectInput};
  assign agree     = ~(s_q.sync2 ^ s_q.sync3);
  assign memAddr   = {s_q.pageBase, s_q.commitIdx[6:0]};

  // ---------------------------------------------------------------------
  // Write data buffer
  // ---------------------------------------------------------------------
  setws_fifo #(
    .WIDTH (setws_pkg::WBYTE_W),
    .DEPTH (setws_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inData   (pushByte),
    .inValid  (push),
    .inReady  (fifoReady),
    .outData  (popByte),
    .outValid (fifoValid),
    .outReady (1'b1)
  );

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    push     = 1'b0;
    pushByte = '{offset: s_q.addr[6:0], data: s_q.shift};
    memWe    = 1'b0;

    // Three-stage sync, value accepted once stages two and three agree
    s_d.sync1 = pinsNow;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.filt  = (agree & s_q.sync3) | (~agree & s_q.filt);
    s_d.sclPrev = scl;
    s_d.sdaPrev = sda;

    if (startCond || stopCond) begin
      s_d.state   = startCond ? setws_pkg::ST_DEV : setws_pkg::ST_IDLE;
      s_d.bitCnt  = 4'h0;
      s_d.ackSlot = 1'b0;
      s_d.sdaLow  = 1'b0;
      // A restart also ends a write transaction
      s_d.pending = s_q.pending | s_q.wrAct;
      s_d.wrAct   = 1'b0;
    end else if (s_q.state != setws_pkg::ST_IDLE) begin
      if (sclRise) begin
        if (!s_q.ackSlot) begin
          if (s_q.bitCnt != setws_pkg::BIT_FULL) begin
            s_d.shift  = {s_q.shift[6:0], sda};
            s_d.bitCnt = s_q.bitCnt + 4'h1;
          end
        end else if (s_q.state == setws_pkg::ST_RDAT && !s_q.sdaLow) begin
          // Own address ack is no byte boundary of the read stream
          s_d.addr = s_q.addr + 16'h0001;
          if (sda) begin
            s_d.state = setws_pkg::ST_IDLE;
          end
        end
      end

      if (sclFall) begin
        if (s_q.ackSlot) begin
          s_d.ackSlot = 1'b0;
          s_d.bitCnt  = 4'h0;
          s_d.sdaLow  = (s_q.state == setws_pkg::ST_RDAT) & ~rdData_q[7];
        end else if (s_q.state == setws_pkg::ST_RDAT) begin
          if (s_q.bitCnt == setws_pkg::BIT_FULL) begin
            s_d.ackSlot = 1'b1;
            s_d.sdaLow  = 1'b0;
          end else begin
            s_d.sdaLow = ~rdData_q[3'(4'h7 - s_q.bitCnt)];
          end
        end else if (s_q.bitCnt == setws_pkg::BIT_FULL) begin
          s_d.ackSlot = 1'b1;
          s_d.sdaLow  = 1'b1;
          case (s_q.state)
            setws_pkg::ST_DEV: begin
              // Busy parts stay silent so a master can poll for completion
              if (s_q.shift[7:1] != myAddr || s_q.busy || s_q.pending) begin
                s_d.sdaLow = 1'b0;
                s_d.state  = setws_pkg::ST_IDLE;
              end else begin
                s_d.state = s_q.shift[0] ? setws_pkg::ST_RDAT
                                         : setws_pkg::ST_AHI;
              end
            end
            setws_pkg::ST_AHI: begin
              s_d.addr[15:8] = s_q.shift;
              s_d.state      = setws_pkg::ST_ALO;
            end
            setws_pkg::ST_ALO: begin
              s_d.addr[7:0] = s_q.shift;
              s_d.pageBase  = {s_q.addr[15:8], s_q.shift[7]};
              s_d.mask      = '0;
              s_d.wrAct     = 1'b1;
              s_d.state     = setws_pkg::ST_WDAT;
            end
            setws_pkg::ST_WDAT: begin
              push = 1'b1;
              if (fifoReady) begin
                // Offset wraps inside the page
                s_d.addr[6:0] = s_q.addr[6:0] + 7'h01;
              end else begin
                s_d.sdaLow = 1'b0;
                s_d.state  = setws_pkg::ST_IDLE;
              end
            end
            default: begin
              s_d.sdaLow = 1'b0;
              s_d.state  = setws_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end

    // Drain the buffer into the page image
    if (fifoValid) begin
      s_d.mask[popByte.offset] = 1'b1;
    end

    // Inhibit decides before any cycle starts
    if (s_q.pending && !fifoValid && !s_q.busy) begin
      s_d.pending = 1'b0;
      if (s_q.mask != '0 && !s_q.filt.writeInhibit) begin
        s_d.busy      = 1'b1;
        s_d.commitIdx = 8'h00;
        s_d.timer     = '0;
      end
    end

    // Self-timed cycle; commit walk fits in its first 128 cycles
    if (s_q.busy) begin
      s_d.timer = s_q.timer + 1'b1;
      if (s_q.commitIdx != 8'(setws_pkg::PAGE_SIZE)) begin
        memWe         = s_q.mask[s_q.commitIdx[6:0]];
        s_d.commitIdx = s_q.commitIdx + 8'h01;
      end
      if (s_q.timer == setws_pkg::TIMER_W'(WRITE_CYCLES - 1)) begin
        s_d.busy = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.sync1 <= setws_pkg::PINS_RESET;
      s_q.sync2 <= setws_pkg::PINS_RESET;
      s_q.sync3 <= setws_pkg::PINS_RESET;
      s_q.filt  <= setws_pkg::PINS_RESET;
      s_q.sclPrev <= 1'b1;
      s_q.sdaPrev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (fifoValid) begin
      pageBuf[popByte.offset] <= popByte.data;
    end
    if (memWe) begin
      memArray[memAddr] <= pageBuf[s_q.commitIdx[6:0]];
    end
    // Read word follows the address; settled long before a bus fall
    rdData_q <= memArray[s_q.addr];
  end

endmodule : setws_slave

/* test/setws_master_model.sv */
// Behavioural two-wire bus master facing the serial memory slave.
// Assumes the bench resolves a pulled-up data wire from all pulls.
module setws_master_model (
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaPull
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock rests high between frames
  initial begin
    sclOut  = 1'b1;
    sdaPull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  // 32-cycle bit, about 780 kHz, inside the bus speed limit
  task automatic bitIo(input logic b, output logic r);
    tick(4);
    sdaPull = !b;
    tick(12);
    sclOut = 1'b1;
    tick(8);
    r = sdaWire;
    tick(8);
    sclOut = 1'b0;
  endtask : bitIo

  task automatic start();
    tick(4);
    sdaPull = 1'b0;
    tick(12);
    sclOut = 1'b1;
    tick(16);
    sdaPull = 1'b1;
    tick(16);
    sclOut = 1'b0;
  endtask : start

  task automatic stop();
    tick(4);
    sdaPull = 1'b1;
    tick(12);
    sclOut = 1'b1;
    tick(16);
    sdaPull = 1'b0;
    tick(16);
  endtask : stop

  // Eight bits, first bit first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic tail,
                      output logic [7:0] q, output logic slot);
    for (int i = 7; i >= 0; i--)
      bitIo(d[i], q[i]);
    bitIo(tail, slot);
  endtask : xfer
endmodule : setws_master_model

/* test/setws_slave_sva.sv */
// Port checks of the two-wire serial memory slave.
// Assumes bus phases of over eight ref_clk cycles and static straps.
module setws_slave_sva #(
  parameter int unsigned WRITE_CYCLES = setws_pkg::WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic writeInhibit,
  input wire logic writeBusy
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned busyCnt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= writeBusy ? busyCnt + 1 : 0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence busyStart;
    $rose(writeBusy);
  endsequence
  sequence oeHeld;
    $stable(sdaOe) [*8];
  endsequence

  drive_low_a: assert property (!sdaOut)
    else $error("data driven high");
  oe_on_low_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data changed while clock high");
  oe_stands_a: assert property ($rose(sclIn) |-> oeHeld)
    else $error("data moved after clock rise");
  busy_length_a: assert property ($fell(writeBusy) |->
    busyCnt == WRITE_CYCLES) else $error("write cycle length wrong");
  busy_bound_a: assert property (busyCnt <= WRITE_CYCLES)
    else $error("write cycle overran");
  inhibit_blocks_a: assert property (busyStart |->
    !$past(writeInhibit, 5)) else $error("write ran while inhibited");
  busy_no_ack_a: assert property (writeBusy && $past(writeBusy)
    |-> !$rose(sdaOe)) else $error("acknowledge while busy");
  busy_after_stop_a: assert property (busyStart |-> sclIn && sdaIn)
    else $error("write started with bus active");
  reset_quiet_a: assert property ($rose(rst_n) |-> !sdaOe && !writeBusy)
    else $error("outputs active out of reset");
endmodule : setws_slave_sva

bind setws_slave setws_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES))
  u_setws_slave_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .writeInhibit(writeInhibit),
  .writeBusy(writeBusy));

/* test/test_setws_slave.sv */
// Self-checking bench of the two-wire serial memory slave.
// Assumes the master model and the bound checker are compiled first.
module test_setws_slave;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned WCYC = 1000;
  localparam logic [3:0]  DEV  = 4'hA;
  logic       ref_clk;
  logic       rst_n;
  logic       sclOut;
  logic       sdaPull;
  logic       sdaOut;
  logic       sdaOe;
  logic [2:0] sel;
  logic       writeInhibit;
  logic       writeBusy;
  logic       sdaWire;
  logic [7:0] q;
  logic       slot;
  int         failures;
  int         cmp_count;

  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & !sdaPull;

  setws_slave #(.WRITE_CYCLES(WCYC), .DEVICE_CODE(DEV)) u_setws_slave (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclOut), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .select_input_bit0(sel[0]),
    .select_input_bit1(sel[1]), .select_input_bit2(sel[2]),
    .writeInhibit(writeInhibit), .writeBusy(writeBusy));
  setws_master_model u_setws_master_model (.ref_clk(ref_clk),
    .sdaWire(sdaWire), .sclOut(sclOut), .sdaPull(sdaPull));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end

  task automatic results();
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic checkBit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : checkBit

  task automatic checkByte(input string n, input logic [7:0] e,
                           input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : checkByte

  task automatic send(input logic [7:0] d, input logic e);
    u_setws_master_model.xfer(d, 1'b1, q, slot);
    checkBit("ack", e, !slot);
  endtask : send

  task automatic setAddr(input logic [15:0] a);
    u_setws_master_model.start();
    send({DEV, sel, 1'b0}, 1'b1);
    send(a[15:8], 1'b1);
    send(a[7:0], 1'b1);
  endtask : setAddr

  task automatic readCheck(input logic [15:0] a, input logic [7:0] e0,
                           input logic [7:0] e1);
    setAddr(a);
    u_setws_master_model.start();
    send({DEV, sel, 1'b1}, 1'b1);
    u_setws_master_model.xfer(8'hFF, 1'b0, q, slot);
    checkByte("read first", e0, q);
    u_setws_master_model.xfer(8'hFF, 1'b1, q, slot);
    checkByte("read next", e1, q);
    u_setws_master_model.stop();
  endtask : readCheck

  // Polls the device once mid-cycle; it must refuse, then the cycle must end
  task automatic busyWait(input logic e);
    checkBit("busy", e, writeBusy);
    if (e) begin
      u_setws_master_model.start();
      send({DEV, sel, 1'b1}, 1'b0);
      u_setws_master_model.stop();
      for (int n = 0; n < WCYC + 100 && writeBusy; n++)
        u_setws_master_model.tick(1);
      checkBit("busy end", 1'b0, writeBusy);
    end
  endtask : busyWait

  task automatic testPageWrap();
    setAddr(16'h12FE);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    send(8'h44, 1'b1);
    u_setws_master_model.stop();
    busyWait(1'b1);
    readCheck(16'h12FE, 8'h11, 8'h22);
    readCheck(16'h1280, 8'h33, 8'h44);
  endtask : testPageWrap

  task automatic testInhibit();
    writeInhibit = 1'b1;
    setAddr(16'h12FE);
    send(8'h5A, 1'b1);
    u_setws_master_model.stop();
    busyWait(1'b0);
    readCheck(16'h12FE, 8'h11, 8'h22);
    writeInhibit = 1'b0;
    setAddr(16'h12FF);
    send(8'hC3, 1'b1);
    u_setws_master_model.stop();
    busyWait(1'b1);
    readCheck(16'h12FE, 8'h11, 8'hC3);
  endtask : testInhibit

  task automatic testSelect();
    sel = 3'h5;
    u_setws_master_model.tick(8);
    for (int s = 0; s < 8; s++) begin
      u_setws_master_model.start();
      send({DEV, 3'(s), 1'b0}, s == 5);
      u_setws_master_model.stop();
    end
    readCheck(16'h1280, 8'h33, 8'h44);
  endtask : testSelect

  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    results();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    sel = 3'h0;
    writeInhibit = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    u_setws_master_model.tick(8);
    testPageWrap();
    testInhibit();
    testSelect();
    results();
  end
endmodule : test_setws_slave
